/* File: src/mfr_bank_map.vh */
// Command codes, reset values and format constants of the command bank.
`ifndef MFR_BANK_MAP_VH
`define MFR_BANK_MAP_VH
`define CMD_TRIM_CODE 8'hE0
`define CMD_PG_DELAY 8'hE1
`define CMD_SUP_FIRST 8'hE2
`define CMD_SUP_INTERVAL 8'hE3
`define CMD_PAGE_MASK 8'hE4
`define CMD_PAD_LEVELS 8'hE5
`define CMD_ADDR_BASE 8'hE6
`define CMD_PART_ID 8'hE7
`define CMD_LOT_CODE 8'hE8
`define CMD_OFF_COEF 8'hE9
`define CMD_LOG_SAVE 8'hEA
`define CMD_LOG_RELOAD 8'hEB
`define CMD_LOG_ERASE 8'hEC
`define CMD_LOG_STATE 8'hED
`define CMD_LOG_BLOCK 8'hEE
`define CMD_SHARED_STATE 8'hEF
`define CMD_SCRATCH 8'hF7
`define CMD_RSVD_A 8'hF8
`define CMD_PAGED_SCRATCH 8'hF9
`define CMD_RSVD_B 8'hFA
`define CMD_VOUT_LOW 8'hFB
`define CMD_VIN_LOW 8'hFC
`define CMD_TEMP_LOW 8'hFD
`define RST_TRIM_CODE 16'h0000
`define RST_PG_DELAY 16'hEB20
`define RST_SUP_INTERVAL 16'h8000
`define RST_PAGE_MASK 8'hFF
`define RST_ADDR_BASE 8'h5C
`define RST_OFF_COEF 16'hC200
`define RST_SCRATCH 16'h0000
`define RST_LOWEST 16'hFFFF
`define PAGE_GLOBAL 8'hFF
`define LOG_LEAD_BYTE 8'hFF
`define LOG_BLOCK_LEN 9'h100
`define LOG_BYTES 9'h0FF
`define L11_EXP_MSB 15
`define L11_EXP_LSB 11
`define L11_MAN_MSB 10
`define L16_EXPONENT 5'h13
`define TRIM_WIDTH 10
`define LOG_STATE_LOCK 0
`define LOG_STATE_VALID 1
`endif

/* File: src/mfr_command_bank.v */
// Manufacturer command bank of an eight-channel power system manager.
// What this block does
// - Per-page read/write word drives each channel's 10-bit trim converter, reset zero.
// - Non-paged power-good delay word, short linear milliseconds, reset means 100 ms.
// - Two supervisor interval words, first and later, both reset to encoded zero.
// - Byte mask picks channels served under the global page; all eight by default.
// - Word read returns live pad levels; writes to it do nothing.
// - Read-only word returns a fixed part identification code.
// - Read-only paged byte returns the configuration lot code.
// - Per-page coefficient times commanded voltage gives the off threshold; default 2.0.
// - Send-byte save command copies the working log into nonvolatile store.
// - Save command acts like a channel fault shutdown, but a fault shutdown saves only while the log is unlocked.
// - Send-byte reload command copies the stored log back to working memory.
// - Send-byte erase command clears the stored log area and its lock.
// - Log block read gives 256 bytes: 0xFF then 255 log bytes in order.
// - Read-only shared status byte with the family-wide bit layout.
// - Lowest output voltage per channel, input voltage and die temperature kept.
// - Short linear words: signed 5-bit exponent high, signed 11-bit mantissa low.
// - Output-voltage words are unsigned with a fixed exponent of minus thirteen.
// - Pages 0 to 7 steer paged commands to that channel; others reserved.
`include "mfr_bank_map.vh"

module mfr_command_bank #(
  parameter CHANNELS = 8,
  parameter LOG_DEPTH = 255,
  // Arbitrary neutral identity values.
  parameter [15:0] PART_ID = 16'h5A01,
  parameter [7:0] LOT_CODE = 8'h3C
) (
  // Clock and reset.
  input wire sys_clk,
  input wire sys_rst,
  // Command port from the serial engine.
  input wire [7:0] page,
  input wire [7:0] cmdCode,
  input wire wrStrobe,
  input wire [15:0] wrData,
  input wire rdStrobe,
  input wire sendStrobe,
  output reg [15:0] rdData,
  output reg rdValid,
  output reg rdError,
  // Live inputs.
  input wire [15:0] padInputs,
  input wire [7:0] sharedStatus,
  input wire measValid,
  input wire [2:0] measChannel,
  input wire [15:0] measVout,
  input wire [15:0] measVin,
  input wire [15:0] measTemp,
  input wire channelFaultOff,
  // Working log side.
  input wire [7:0] logWrData,
  input wire logWrEn,
  input wire [7:0] logWrAddr,
  // Configuration outputs.
  output reg [8*`TRIM_WIDTH-1:0] trimCodes,
  output reg [15:0] powerGoodDelay,
  output reg [15:0] supervisorFirst,
  output reg [15:0] supervisorLater,
  output reg [7:0] globalPageMask,
  output reg [7:0] busAddressBase,
  output reg [8*16-1:0] offCoefficients,
  output reg faultOffEvent
);

  ////////////////////////////////////////////////////////////////////////////
  reg [15:0] trimWord [0:7];
  reg [15:0] coefWord [0:7];
  reg [15:0] pagedScratch [0:7];
  reg [15:0] voutLow [0:7];
  reg [15:0] scratch;
  reg [15:0] vinLow;
  reg [15:0] tempLow;
  reg [7:0] workLog [0:255];
  reg [7:0] storeLog [0:255];
  reg [7:0] logState;
  reg [8:0] blockIdx;
  reg [1:0] copyMode;
  reg [8:0] copyIdx;
  integer i;

  localparam MODE_IDLE = 2'd0;
  localparam MODE_SAVE = 2'd1;
  localparam MODE_RELOAD = 2'd2;
  localparam MODE_ERASE = 2'd3;

  wire pageOk = page < 8'h08;
  wire [2:0] pg = page[2:0];

  // Unsigned output-voltage words compare directly.
  function lessU;
    input [15:0] a;
    input [15:0] b;
    lessU = a < b;
  endfunction

  // Short linear compare through a scaled signed value.
  function signed [47:0] l11Val;
    input [15:0] w;
    reg signed [4:0] e;
    reg signed [47:0] m;
    begin
      e = w[`L11_EXP_MSB:`L11_EXP_LSB];
      m = {{37{w[`L11_MAN_MSB]}}, w[`L11_MAN_MSB:0]};
      l11Val = (m <<< 16) <<< e;
      if (e < 0) begin
        l11Val = (m <<< 16) >>> (-e);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      for (i = 0; i < 8; i = i + 1) begin
        trimWord[i] <= `RST_TRIM_CODE;
        coefWord[i] <= `RST_OFF_COEF;
        pagedScratch[i] <= `RST_SCRATCH;
        voutLow[i] <= `RST_LOWEST;
      end
      powerGoodDelay <= `RST_PG_DELAY;
      supervisorFirst <= `RST_SUP_INTERVAL;
      supervisorLater <= `RST_SUP_INTERVAL;
      globalPageMask <= `RST_PAGE_MASK;
      busAddressBase <= `RST_ADDR_BASE;
      scratch <= `RST_SCRATCH;
      vinLow <= 16'h7BFF;
      tempLow <= 16'h7BFF;
      rdData <= 16'h0000;
      rdValid <= 1'b0;
      rdError <= 1'b0;
      blockIdx <= 9'h000;
      copyMode <= MODE_IDLE;
      copyIdx <= 9'h000;
      logState <= 8'h00;
      faultOffEvent <= 1'b0;
    end else begin
      rdValid <= 1'b0;
      rdError <= 1'b0;
      faultOffEvent <= 1'b0;
      if (wrStrobe) begin
        case (cmdCode)
          `CMD_TRIM_CODE: if (pageOk) trimWord[pg] <= wrData;
          `CMD_PG_DELAY: powerGoodDelay <= wrData;
          `CMD_SUP_FIRST: supervisorFirst <= wrData;
          `CMD_SUP_INTERVAL: supervisorLater <= wrData;
          `CMD_PAGE_MASK: globalPageMask <= wrData[7:0];
          `CMD_ADDR_BASE: busAddressBase <= wrData[7:0];
          `CMD_OFF_COEF: if (pageOk) coefWord[pg] <= wrData;
          `CMD_SCRATCH: scratch <= wrData;
          `CMD_PAGED_SCRATCH: if (pageOk) pagedScratch[pg] <= wrData;
          default: rdError <= 1'b0;
        endcase
      end
      if (rdStrobe) begin
        rdValid <= 1'b1;
        rdData <= 16'h0000;
        if (cmdCode != `CMD_LOG_BLOCK) begin
          blockIdx <= 9'h000;
        end
        case (cmdCode)
          `CMD_TRIM_CODE: rdData <= trimWord[pg];
          `CMD_PG_DELAY: rdData <= powerGoodDelay;
          `CMD_SUP_FIRST: rdData <= supervisorFirst;
          `CMD_SUP_INTERVAL: rdData <= supervisorLater;
          `CMD_PAGE_MASK: rdData <= {8'h00, globalPageMask};
          `CMD_PAD_LEVELS: rdData <= padInputs;
          `CMD_ADDR_BASE: rdData <= {8'h00, busAddressBase};
          `CMD_PART_ID: rdData <= PART_ID;
          `CMD_LOT_CODE: rdData <= {8'h00, LOT_CODE};
          `CMD_OFF_COEF: rdData <= coefWord[pg];
          `CMD_LOG_STATE: rdData <= {8'h00, logState};
          `CMD_SHARED_STATE: rdData <= {8'h00, sharedStatus};
          `CMD_SCRATCH: rdData <= scratch;
          `CMD_PAGED_SCRATCH: rdData <= pagedScratch[pg];
          `CMD_VOUT_LOW: rdData <= voutLow[pg];
          `CMD_VIN_LOW: rdData <= vinLow;
          `CMD_TEMP_LOW: rdData <= tempLow;
          `CMD_LOG_BLOCK: begin
            // Leading marker byte, then the log in address order.
            if (blockIdx == 9'h000) begin
              rdData <= {8'h00, `LOG_LEAD_BYTE};
            end else begin
              rdData <= {8'h00, workLog[blockIdx[7:0] - 8'h01]};
            end
            if (blockIdx == `LOG_BYTES) begin
              blockIdx <= 9'h000;
            end else begin
              blockIdx <= blockIdx + 9'h001;
            end
          end
          default: rdError <= 1'b1;
        endcase
        // Paged reads outside channel pages carry no valid data.
        if (!pageOk && (cmdCode == `CMD_TRIM_CODE ||
            cmdCode == `CMD_OFF_COEF || cmdCode == `CMD_LOT_CODE ||
            cmdCode == `CMD_PAGED_SCRATCH || cmdCode == `CMD_VOUT_LOW)) begin
          rdError <= 1'b1;
        end
      end
      if (sendStrobe && copyMode == MODE_IDLE) begin
        case (cmdCode)
          `CMD_LOG_SAVE: begin
            copyMode <= MODE_SAVE;
            faultOffEvent <= 1'b1;
          end
          `CMD_LOG_RELOAD: copyMode <= MODE_RELOAD;
          `CMD_LOG_ERASE: copyMode <= MODE_ERASE;
          default: rdError <= 1'b1;
        endcase
        copyIdx <= 9'h000;
      end else if (channelFaultOff && copyMode == MODE_IDLE &&
                   !logState[`LOG_STATE_LOCK]) begin
        copyMode <= MODE_SAVE;
        copyIdx <= 9'h000;
        faultOffEvent <= 1'b1;
      end
      // One byte per cycle keeps the store a simple single-port array.
      if (copyMode != MODE_IDLE) begin
        case (copyMode)
          MODE_SAVE: storeLog[copyIdx[7:0]] <= workLog[copyIdx[7:0]];
          MODE_RELOAD: workLog[copyIdx[7:0]] <= storeLog[copyIdx[7:0]];
          MODE_ERASE: storeLog[copyIdx[7:0]] <= 8'h00;
          default: copyIdx <= 9'h000;
        endcase
        if (copyIdx == `LOG_BLOCK_LEN - 9'h001) begin
          copyMode <= MODE_IDLE;
          case (copyMode)
            MODE_SAVE: logState <= 8'h03;
            MODE_ERASE: logState <= 8'h00;
            default: logState <= logState;
          endcase
        end
        copyIdx <= copyIdx + 9'h001;
      end else if (logWrEn) begin
        workLog[logWrAddr] <= logWrData;
      end
      if (measValid) begin
        if (lessU(measVout, voutLow[measChannel])) begin
          voutLow[measChannel] <= measVout;
        end
        if (l11Val(measVin) < l11Val(vinLow)) begin
          vinLow <= measVin;
        end
        if (l11Val(measTemp) < l11Val(tempLow)) begin
          tempLow <= measTemp;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      trimCodes <= {8*`TRIM_WIDTH{1'b0}};
      offCoefficients <= {8{`RST_OFF_COEF}};
    end else begin
      for (i = 0; i < 8; i = i + 1) begin
        trimCodes[i*`TRIM_WIDTH +: `TRIM_WIDTH] <=
          trimWord[i][`TRIM_WIDTH-1:0];
        offCoefficients[i*16 +: 16] <= coefWord[i];
      end
    end
  end

endmodule // mfr_command_bank

/* File: testbench/bank_host_model.sv */
// Host controller model that issues bank commands.
module bank_host_model (
  // Clock.
  input wire sys_clk,
  // Command port toward the bank.
  output logic [7:0] page = 8'h00,
  output logic [7:0] cmdCode = 8'h00,
  output logic wrStrobe = 1'b0,
  output logic [15:0] wrData = 16'h0000,
  output logic rdStrobe = 1'b0,
  output logic sendStrobe = 1'b0,
  input wire [15:0] rdData,
  input wire rdValid,
  input wire rdError
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wr(input [7:0] c, p, input [15:0] d);
    @(posedge sys_clk);
    cmdCode <= c;
    page <= p;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge sys_clk);
    wrStrobe <= 1'b0;
    // A released data bus must not keep showing the last word.
    wrData <= ~d;
  endtask
  // Returns {valid, error, data} seen one cycle after the request.
  task automatic rd(input [7:0] c, p, output [17:0] q);
    @(posedge sys_clk);
    cmdCode <= c;
    page <= p;
    rdStrobe <= 1'b1;
    @(posedge sys_clk);
    rdStrobe <= 1'b0;
    @(negedge sys_clk);
    q = {rdValid, rdError, rdData};
  endtask
  task automatic snd(input [7:0] c);
    @(posedge sys_clk);
    cmdCode <= c;
    sendStrobe <= 1'b1;
    @(posedge sys_clk);
    sendStrobe <= 1'b0;
    @(negedge sys_clk);
  endtask
endmodule // bank_host_model

/* File: testbench/mfr_bank_monitor.sv */
// Port-level checks of the command bank.
`include "mfr_bank_map.vh"
module mfr_bank_monitor #(
  parameter [15:0] PART_ID = 16'h5A01
) (
  // Clock and reset.
  input wire sys_clk,
  input wire sys_rst,
  // Command port.
  input wire [7:0] page,
  input wire [7:0] cmdCode,
  input wire wrStrobe,
  input wire [15:0] wrData,
  input wire rdStrobe,
  input wire sendStrobe,
  input wire [15:0] rdData,
  input wire rdValid,
  // Live inputs and outputs.
  input wire [15:0] padInputs,
  input wire channelFaultOff,
  input wire [8*`TRIM_WIDTH-1:0] trimCodes,
  input wire [15:0] powerGoodDelay,
  input wire [15:0] supervisorFirst,
  input wire [7:0] globalPageMask,
  input wire [7:0] busAddressBase,
  input wire faultOffEvent
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire [47:0] cfg = {powerGoodDelay, supervisorFirst, globalPageMask,
    busAddressBase};
  a_id_read: assert property (rdStrobe && cmdCode == `CMD_PART_ID
    |=> rdValid && rdData == PART_ID) else $error("id read");
  a_pad_live: assert property (rdStrobe && cmdCode == `CMD_PAD_LEVELS
    |=> rdValid && rdData == $past(padInputs)) else $error("pad read");
  a_delay_write: assert property (wrStrobe && cmdCode == `CMD_PG_DELAY
    |=> powerGoodDelay == $past(wrData)) else $error("delay write");
  a_reset_vals: assert property ($fell(sys_rst) |-> cfg ==
    48'hEB20_8000_FF5C) else $error("reset values");
  a_ro_ignored: assert property (wrStrobe && (cmdCode == `CMD_PART_ID ||
    cmdCode == `CMD_PAD_LEVELS) |=> $stable(cfg)) else $error("ro write");
  a_bad_page: assert property (wrStrobe && page > 8'h07
    |=> ##1 trimCodes == $past(trimCodes, 2)) else $error("bad page");
  a_event_cause: assert property (faultOffEvent |->
    $past(sendStrobe && cmdCode == `CMD_LOG_SAVE) || $past(channelFaultOff))
    else $error("event cause");
  a_event_pulse: assert property (faultOffEvent |=> !faultOffEvent)
    else $error("event width");
  c_read: cover property (rdValid);
  c_event: cover property (faultOffEvent);
  c_bad_page: cover property (wrStrobe && page > 8'h07);
endmodule // mfr_bank_monitor
bind mfr_command_bank mfr_bank_monitor #(.PART_ID(PART_ID)) mon (.*);

/* File: testbench/tb_top.sv */
// Self-checking bench for the command bank.
`include "mfr_bank_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [15:0] ID = 16'h5A01; // Arbitrary identity value.
  logic sys_clk = 0, sys_rst = 1, logWrEn = 0, measValid = 0;
  logic channelFaultOff = 0;
  logic [7:0] logWrAddr = 0, logWrData = 0, sharedStatus = 0;
  logic [15:0] padInputs = 0, measVout = 0, measVin = 0, measTemp = 0;
  logic [2:0] measChannel = 3'h1;
  wire [7:0] page, cmdCode, globalPageMask, busAddressBase;
  wire [15:0] wrData, rdData, powerGoodDelay, supervisorFirst;
  wire [15:0] supervisorLater;
  wire wrStrobe, rdStrobe, sendStrobe, rdValid, rdError, faultOffEvent;
  wire [79:0] trimCodes;
  wire [127:0] offCoefficients;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  logic [17:0] q;
  logic [48:0] rows [14] = '{
    {8'hE0, 8'h00, 1'b0, 16'h0000, 16'h0000},
    {8'hE1, 8'h00, 1'b0, 16'h0000, 16'hEB20},
    {8'hE2, 8'h00, 1'b0, 16'h0000, 16'h8000},
    {8'hE3, 8'h00, 1'b0, 16'h0000, 16'h8000},
    {8'hE4, 8'h00, 1'b0, 16'h0000, 16'h00FF},
    {8'hE6, 8'h00, 1'b0, 16'h0000, 16'h005C},
    {8'hE9, 8'h05, 1'b0, 16'h0000, 16'hC200},
    {8'hE8, 8'h02, 1'b0, 16'h0000, 16'h003C},
    {8'hE0, 8'h07, 1'b1, 16'h03FF, 16'h03FF},
    {8'hE3, 8'h00, 1'b1, 16'h1234, 16'h1234},
    {8'hE1, 8'h00, 1'b1, 16'h1388, 16'h1388},
    {8'hE4, 8'h00, 1'b1, 16'h0055, 16'h0055},
    {8'hE9, 8'h02, 1'b1, 16'h4000, 16'h4000},
    {8'hF9, 8'h03, 1'b1, 16'hABCD, 16'hABCD}};
  always #50 sys_clk = ~sys_clk;
  bank_host_model host (.*);
  mfr_command_bank #(.PART_ID(ID)) uut (.*);
  task automatic chk(input [17:0] g, e, m);
    n_tests++;
    if ((g & m) !== (e & m)) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, g & m, e & m);
    end
  endtask
  task automatic results;
    $display("Tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic strobe(input [2:0] k);
    @(posedge sys_clk);
    logWrEn <= k[0];
    measValid <= k[1];
    channelFaultOff <= k[2];
    @(posedge sys_clk);
    {channelFaultOff, measValid, logWrEn} <= 3'b000;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    logic [48:0] r;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 0;
    foreach (rows[k]) begin
      r = rows[k];
      if (r[32]) host.wr(r[48:41], r[40:33], r[31:16]);
      host.rd(r[48:41], r[40:33], q);
      chk(q, {2'b10, r[15:0]}, 18'h3_FFFF);
    end
    chk({8'h00, trimCodes[79:70]}, 18'h0_03FF, 18'h3_FFFF);
    chk({2'b00, offCoefficients[47:32]}, 18'h0_4000, 18'h3_FFFF);
    chk({2'b00, supervisorLater}, 18'h0_1234, 18'h3_FFFF);
    chk({2'b00, powerGoodDelay}, 18'h0_1388, 18'h3_FFFF);
    chk({10'h000, globalPageMask}, 18'h0_0055, 18'h3_FFFF);
    host.wr(8'hE0, 8'h08, 16'h0001);
    host.rd(8'hE0, 8'h00, q);
    chk(q, 18'h2_0000, 18'h3_FFFF);
    host.rd(8'hE0, 8'h08, q);
    chk(q, 18'h1_0000, 18'h1_0000);
    host.wr(8'hE7, 8'h00, 16'h0000);
    host.rd(8'hE7, 8'h00, q);
    chk(q, {2'b10, ID}, 18'h3_FFFF);
    padInputs <= 16'hA55A;
    sharedStatus <= 8'h96;
    host.rd(8'hE5, 8'h00, q);
    chk(q, 18'h2_A55A, 18'h3_FFFF);
    host.rd(8'hEF, 8'h00, q);
    chk(q, 18'h2_0096, 18'h3_00FF);
    for (int i = 0; i < 2; i++) begin
      {measVout, measVin, measTemp} <= {16'h3000, 16'h0100, 16'h0010} << i;
      strobe(3'b010);
    end
    host.rd(8'hFB, 8'h01, q);
    chk(q, 18'h2_3000, 18'h3_FFFF);
    host.rd(8'hFC, 8'h00, q);
    chk(q, 18'h2_0100, 18'h3_FFFF);
    host.rd(8'hFD, 8'h00, q);
    chk(q, 18'h2_0010, 18'h3_FFFF);
    for (int i = 0; i < 255; i++) begin
      {logWrAddr, logWrData} <= {8'(i), 8'(i) ^ 8'hA5};
      strobe(3'b001);
    end
    host.snd(8'hEA);
    chk({17'h0, faultOffEvent}, 18'h1, 18'h1);
    // The copy takes 256 cycles and ignores new sends meanwhile.
    repeat (260) @(posedge sys_clk);
    host.rd(8'hED, 8'h00, q);
    chk(q, 18'h2_0003, 18'h3_00FF);
    {logWrAddr, logWrData} <= 16'h0000;
    strobe(3'b001);
    host.snd(8'hEB);
    repeat (260) @(posedge sys_clk);
    for (int i = 0; i < 256; i++) begin
      host.rd(8'hEE, 8'h00, q);
      r[7:0] = i == 0 ? 8'hFF : 8'(i - 1) ^ 8'hA5;
      chk(q, {10'h200, r[7:0]}, 18'h3_00FF);
    end
    host.snd(8'hEC);
    repeat (260) @(posedge sys_clk);
    host.rd(8'hED, 8'h00, q);
    chk(q, 18'h2_0000, 18'h3_00FF);
    strobe(3'b100);
    @(negedge sys_clk);
    chk({17'h0, faultOffEvent}, 18'h1, 18'h1);
    results();
  end
endmodule // tb_top
